// ==== rtl/lra_limit_relay.sv ====
// Limit relay alarm logic with Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module lra_limit_relay #(
   parameter int NUM_CH  = lra_pkg::NUM_CH,
   parameter int NUM_LIM = lra_pkg::NUM_LIM,
   parameter int RD_W    = lra_pkg::RD_W
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [7:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   input  wire lra_pkg::lra_sample_t      sample_i,
   input  wire logic [0:0]                sel_ch_i,
   input  wire logic [1:0]                sel_lim_i,
   input  wire logic                      data_key_i,
   input  wire logic                      reset_key_i,
   output logic      [NUM_CH*NUM_LIM-1:0] relay_closed_o,
   output logic                           buzzer_o,
   output logic                           irq_o
);
   ////////////////////////////////////////////////////////////////////////
   // Register storage
   lra_pkg::lra_cfg_t                 cfg   [NUM_CH];
   logic signed [RD_W-1:0]            lim   [NUM_CH][NUM_LIM];
   logic signed [RD_W-1:0]            last  [NUM_CH];
   logic        [NUM_CH*NUM_LIM-1:0]  active;
   logic        [NUM_CH*NUM_LIM-1:0]  irq_stat;
   logic        [NUM_CH*NUM_LIM-1:0]  irq_mask;
   logic                              buzz_en;
   logic                              key_prev;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire        wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
   wire [1:0]  wb_wr_hi  = {2{wb_req & wb_we_i}} & wb_sel_i[3:2];
   wire        is_ch     = wb_adr_i >= lra_pkg::OFS_CH_BASE;
   wire [7:0]  ch_off    = wb_adr_i - lra_pkg::OFS_CH_BASE;
   wire [3:0]  ch_idx    = ch_off[7:4];
   wire [3:0]  sub       = ch_off[3:0];
   wire        ch_ok     = is_ch & (ch_idx < 4'(NUM_CH));
   wire [0:0]  cix       = ch_idx[0:0];
   wire [1:0]  lix       = 2'(sub[3:2] - 2'h1);
   wire [RD_W-1:0] db_new = wb_dat_i[lra_pkg::CFG_DB_LSB +: RD_W];
   // Deadband below minimum is refused; old value kept
   wire        db_ok     = db_new >= 16'(lra_pkg::DB_MIN);

   lra_pkg::lra_cfg_t rd_cfg;
   assign rd_cfg = cfg[cix];
   wire [31:0] rd_ch = (sub == lra_pkg::SUB_CFG) ?
                       {rd_cfg.deadband, 11'h000, rd_cfg.nc, rd_cfg.latch, rd_cfg.on} :
                       {{(32-RD_W){lim[cix][lix][RD_W-1]}}, lim[cix][lix]};
   wire [31:0] rd_mux =
      (wb_adr_i == lra_pkg::OFS_SYS_CTRL) ? {31'h0, buzz_en} :
      (wb_adr_i == lra_pkg::OFS_IRQ_STAT) ? {26'h0, irq_stat} :
      (wb_adr_i == lra_pkg::OFS_IRQ_MASK) ? {26'h0, irq_mask} :
      (wb_adr_i == lra_pkg::OFS_ACTIVE)   ? {26'h0, active} :
      ch_ok ? rd_ch : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System control and interrupt registers
   wire stat_wr = wb_wr & (wb_adr_i == lra_pkg::OFS_IRQ_STAT);
   wire mask_wr = wb_wr & (wb_adr_i == lra_pkg::OFS_IRQ_MASK);
   wire sys_wr  = wb_wr & (wb_adr_i == lra_pkg::OFS_SYS_CTRL);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buzz_en  <= 1'b0;
         irq_mask <= '0;
      end else begin
         if (sys_wr) begin
            buzz_en <= wb_dat_i[lra_pkg::SYS_BUZZ_EN_BIT];
         end
         if (mask_wr) begin
            irq_mask <= wb_dat_i[NUM_CH*NUM_LIM-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Front panel clear: reset key edge while data key held
   wire        clr_press = reset_key_i & ~key_prev & data_key_i;
   wire signed [RD_W-1:0] sel_lim = lim[sel_ch_i][sel_lim_i];
   // Reading must be below selected limit
   wire        clr_ok    = clr_press & (sel_lim_i < 2'(NUM_LIM)) & (last[sel_ch_i] < sel_lim);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_prev <= 1'b0;
      end else begin
         key_prev <= reset_key_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel configuration, limits and limit state
   logic [NUM_CH*NUM_LIM-1:0] next_active;
   logic [NUM_CH*NUM_LIM-1:0] rise;

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      wire cfg_wr = wb_req & wb_we_i & ch_ok & (cix == 1'(c)) & (sub == lra_pkg::SUB_CFG);
      // Evaluate on new reading of an enabled channel
      wire evaluate = sample_i.valid & (sample_i.ch == 1'(c)) & cfg[c].on;
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cfg[c]  <= '{on: 1'b0, latch: 1'b0, nc: '0, deadband: lra_pkg::DB_RST};
            last[c] <= '0;
         end else begin
            if (cfg_wr && wb_sel_i[0]) begin
               cfg[c].on    <= wb_dat_i[lra_pkg::CFG_ON_BIT];
               cfg[c].latch <= wb_dat_i[lra_pkg::CFG_LATCH_BIT];
               cfg[c].nc    <= wb_dat_i[lra_pkg::CFG_NC_LSB +: NUM_LIM];
            end
            if (cfg_wr && (&wb_wr_hi) && db_ok) begin
               cfg[c].deadband <= db_new;
            end
            if (evaluate) begin
               last[c] <= sample_i.value;
            end
         end
      end
      // Three independent limits each with own output
      for (genvar l = 0; l < NUM_LIM; l++) begin : g_lim
         localparam int K = c*NUM_LIM + l;
         wire lim_wr = wb_req & wb_we_i & ch_ok & (cix == 1'(c)) & (lix == 2'(l)) &
                       (sub != lra_pkg::SUB_CFG) & wb_sel_i[0] & wb_sel_i[1];
         wire signed [RD_W:0] lo   = (RD_W+1)'(lim[c][l]) - (RD_W+1)'($signed({1'b0, cfg[c].deadband}));
         wire over  = sample_i.value > lim[c][l];
         wire under = $signed({sample_i.value[RD_W-1], sample_i.value}) <= lo;
         // Clear only selected channel and limit
         wire clr   = clr_ok & (sel_ch_i == 1'(c)) & (sel_lim_i == 2'(l)) & cfg[c].latch;
         always_comb begin
            next_active[K] = active[K];
            if (evaluate && over) begin
               next_active[K] = 1'b1;
            end else if (evaluate && under && !cfg[c].latch) begin
               next_active[K] = 1'b0;
            // Latched output held until manual clear
            end else if (clr) begin
               next_active[K] = 1'b0;
            end
            rise[K] = next_active[K] & ~active[K];
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               lim[c][l] <= lra_pkg::LIM_RST;
            end else if (lim_wr) begin
               lim[c][l] <= wb_dat_i[RD_W-1:0];
            end
         end
         assign relay_closed_o[K] = active[K] ^ cfg[c].nc[l];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Limit state and sticky interrupt status (set wins over clear)
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active   <= '0;
         irq_stat <= '0;
      end else begin
         active   <= next_active;
         irq_stat <= (irq_stat & ~({(NUM_CH*NUM_LIM){stat_wr}} & wb_dat_i[NUM_CH*NUM_LIM-1:0])) | rise;
      end
   end

   assign irq_o    = |(irq_stat & irq_mask);
   // Buzzer sounds on any active limit when enabled
   assign buzzer_o = buzz_en & (|active);

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   a_limit_activate: assert property (@(posedge clk_i) disable iff (rst_i)
      (sample_i.valid && sample_i.ch == 1'b0 && cfg[0].on && sample_i.value > lim[0][0])
      |=> active[0])
      else $error("limit output not activated above limit");
   a_nonlatch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (active[0] && !clr_ok && sample_i.valid && sample_i.ch == 1'b0 &&
       sample_i.value > $signed(lim[0][0] - $signed(cfg[0].deadband)))
      |=> active[0])
      else $error("output released inside deadband");
   a_deadband_min: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg[0].deadband >= 16'(lra_pkg::DB_MIN))
      else $error("deadband below minimum");
   a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (active[0] && cfg[0].latch && !clr_ok) |=> active[0])
      else $error("latched output dropped without clear");
   a_clear_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (active[0] && cfg[0].latch && !sample_i.valid && clr_press && sel_ch_i == 1'b0 &&
       sel_lim_i == 2'd0 && last[0] >= lim[0][0]) |=> active[0])
      else $error("clear accepted while reading not below limit");
   a_clear_works: assert property (@(posedge clk_i) disable iff (rst_i)
      (cfg[0].latch && !sample_i.valid && clr_ok && sel_ch_i == 1'b0 && sel_lim_i == 2'd0)
      |=> !active[0])
      else $error("valid clear did not release output");
   a_relay_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
      relay_closed_o[1] == (active[1] != cfg[0].nc[1]))
      else $error("relay polarity wrong");
   a_off_skipped: assert property (@(posedge clk_i) disable iff (rst_i)
      (!cfg[1].on && !clr_ok) |=> $stable(active[5:3]))
      else $error("off channel evaluated");
   a_buzzer_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !buzz_en |-> !buzzer_o)
      else $error("buzzer sounded while disabled");
endmodule
`default_nettype wire

// ==== rtl/lra_pkg.sv ====
// Package for the limit relay alarm logic: register map, field layout, types
package lra_pkg;
   localparam int NUM_CH      = 2;
   localparam int NUM_LIM     = 3;
   localparam int RD_W        = 16;
   localparam int DB_MIN      = 2;
   // Register word offsets (byte addresses)
   localparam logic [7:0] OFS_SYS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;
   localparam logic [7:0] OFS_ACTIVE    = 8'h0C;
   localparam logic [7:0] OFS_CH_BASE   = 8'h10;
   localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
   // Per-channel sub offsets
   localparam logic [3:0] SUB_CFG       = 4'h0;
   localparam logic [3:0] SUB_LIM1      = 4'h4;
   localparam logic [3:0] SUB_LIM2      = 4'h8;
   localparam logic [3:0] SUB_LIM3      = 4'hC;
   // System control fields
   localparam int SYS_BUZZ_EN_BIT = 0;
   // Channel config fields
   localparam int CFG_ON_BIT      = 0;
   localparam int CFG_LATCH_BIT   = 1;
   localparam int CFG_NC_LSB      = 2;
   localparam int CFG_DB_LSB      = 16;
   // Reset values
   localparam logic [RD_W-1:0] DB_RST  = 16'h0002;
   localparam logic [RD_W-1:0] LIM_RST = 16'h7FFF;
   typedef struct packed {
      logic                 on;
      logic                 latch;
      logic [NUM_LIM-1:0]   nc;
      logic [RD_W-1:0]      deadband;
   } lra_cfg_t;
   typedef struct packed {
      logic                  valid;
      logic [0:0]            ch;
      logic signed [RD_W-1:0] value;
   } lra_sample_t;
endpackage

// ==== testbench/lra_panel_model.sv ====
// Front panel model: selects a limit and presses the clear key pair
`timescale 1ns/10ps
`default_nettype none
module lra_panel_model (
   input  wire logic       clk_i,
   input  wire logic       req_i,
   input  wire logic       ch_i,
   input  wire logic [1:0] lim_i,
   output logic      [0:0] sel_ch_o,
   output logic      [1:0] sel_lim_o,
   output logic            data_key_o,
   output logic            reset_key_o,
   output logic            done_o
);
   initial begin
      {sel_ch_o, sel_lim_o, data_key_o, reset_key_o, done_o} = '0;
      forever begin
         @(posedge clk_i);
         if (req_i) begin
            sel_ch_o <= ch_i;
            sel_lim_o <= lim_i;
            data_key_o <= 1'b1;
            @(posedge clk_i);
            reset_key_o <= 1'b1;
            @(posedge clk_i);
            reset_key_o <= 1'b0;
            @(posedge clk_i);
            data_key_o <= 1'b0;
            done_o <= 1'b1;
            @(posedge clk_i);
            done_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the limit relay alarm logic
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, rch = 1'b0;
   logic        ack, buz, irq, done, dk, rk;
   logic [0:0]  sch;
   logic [1:0]  rl = 2'h0, slim;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dw = 32'h0, dr, rv;
   logic [5:0]  rel;
   logic [15:0] lf = 16'hC2FA;
   lra_pkg::lra_sample_t smp = '0;
   int err_total = 0, compares = 0, ncyc = 0;
   int lim [6], act [6], nc [6], db = 5, lat = 0, lastv = 0, ben = 0, st = 0, msk = 0;
   int vals [9] = '{101, 100, 96, 95, 201, 196, 195, 301, 0};

   lra_limit_relay lra_limit_relay_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .sample_i(smp), .sel_ch_i(sch), .sel_lim_i(slim), .data_key_i(dk), .reset_key_i(rk),
      .relay_closed_o(rel), .buzzer_o(buz), .irq_o(irq));
   lra_panel_model lra_panel_model_i (.clk_i(clk_i), .req_i(req), .ch_i(rch), .lim_i(rl),
      .sel_ch_o(sch), .sel_lim_o(slim), .data_key_o(dk), .reset_key_o(rk), .done_o(done));

   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      ncyc++;
      if (ncyc > 20000) begin
         err_total++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle, held until ack is seen
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc, stb, we, adr, dw, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (ack !== 1'b1 && n < 50);
      rv = dr;
      @(posedge clk_i);
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   task automatic chk_out;
      logic [5:0] e;
      int b;
      b = 0;
      for (int k = 0; k < 6; k++) begin
         e[k] = (act[k] ^ nc[k]) != 0;
         b |= act[k];
      end
      chk(32'(rel), 32'(e));
      chk(32'(buz), 32'(ben & b));
      chk(32'(irq), 32'((st & msk) != 0));
   endtask
   task automatic sample(input logic ch, input int v);
      @(posedge clk_i);
      smp <= '{1'b1, ch, 16'(v)};
      @(posedge clk_i);
      smp.valid <= 1'b0;
      @(posedge clk_i);
      #1;
      if (!ch) begin
         lastv = v;
         for (int l = 0; l < 3; l++) begin
            if (v > lim[l]) begin
               st |= (act[l] == 0) << l;
               act[l] = 1;
            end else if (lat == 0 && v <= lim[l] - db) act[l] = 0;
         end
      end
   endtask
   task automatic clr(input logic ch, input logic [1:0] l);
      int n;
      @(posedge clk_i);
      {req, rch, rl} <= {1'b1, ch, l};
      @(posedge clk_i);
      req <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (done !== 1'b1 && n < 20);
      @(posedge clk_i);
      #1;
      if (!ch && lat != 0 && lastv < lim[l]) act[l] = 0;
   endtask
   task automatic conclude;
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      for (int k = 0; k < 6; k++) {lim[k], act[k], nc[k]} = {32'h7FFF, 64'h0};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_out();
      rdc(8'h10, 32'h0002_0000);
      rdc(8'h30, 32'h0);
      for (int l = 0; l < 3; l++) begin
         lim[l] = 100 * (l + 1);
         wb(1'b1, 8'h14 + 8'(4 * l), 32'(lim[l]));
         rdc(8'h14 + 8'(4 * l), 32'(lim[l]));
      end
      wb(1'b1, 8'h24, 32'hFF9C);
      rdc(8'h24, 32'hFFFF_FF9C);
      wb(1'b1, 8'h10, 32'h0005_0009);
      wb(1'b1, 8'h10, 32'h0001_0009);
      rdc(8'h10, 32'h0005_0009);
      nc[1] = 1;
      wb(1'b1, 8'h08, 32'h3F);
      msk = 63;
      wb(1'b1, 8'h00, 32'h1);
      ben = 1;
      chk_out();
      foreach (vals[i]) begin
         sample(1'b0, vals[i]);
         chk_out();
      end
      sample(1'b1, 50);
      chk_out();
      repeat (40) begin
         lf = lfsr(lf);
         sample(1'b0, int'(lf) % 400);
         chk_out();
      end
      rdc(8'h0C, 32'({act[5], act[4], act[3], act[2], act[1], act[0]} != 0 ? {26'h0,
         1'(act[5]), 1'(act[4]), 1'(act[3]), 1'(act[2]), 1'(act[1]), 1'(act[0])} : 32'h0));
      rdc(8'h04, 32'(st));
      wb(1'b1, 8'h08, 32'h0);
      msk = 0;
      chk_out();
      wb(1'b1, 8'h04, 32'(st));
      st = 0;
      rdc(8'h04, 32'h0);
      {msk, ben} = {32'd63, 32'd0};
      wb(1'b1, 8'h08, 32'h3F);
      wb(1'b1, 8'h00, 32'h0);
      chk_out();
      wb(1'b1, 8'h10, 32'h0005_000B);
      lat = 1;
      sample(1'b0, 350);
      sample(1'b0, 150);
      chk_out();
      clr(1'b0, 2'd0);
      chk_out();
      clr(1'b1, 2'd1);
      chk_out();
      clr(1'b0, 2'd2);
      chk_out();
      clr(1'b0, 2'd1);
      chk_out();
      sample(1'b0, 50);
      chk_out();
      clr(1'b0, 2'd0);
      chk_out();
      conclude();
   end
endmodule
`default_nettype wire
